/* verilog/sswc_pkg.sv */
package sswc_pkg;
    localparam int          NSUP        = 4;
    localparam int          SECOND_BUCK = 1;
    // bus map
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_STAT      = 8'h04;
    localparam logic [7:0]  A_WD_TMO    = 8'h08;
    localparam logic [7:0]  A_WD_KICK   = 8'h0c;
    localparam logic [7:0]  A_RTC_LO    = 8'h10;
    localparam logic [7:0]  A_RTC_HI    = 8'h14;
    localparam logic [7:0]  A_CMP_LO    = 8'h18;
    localparam logic [7:0]  A_CMP_HI    = 8'h1c;
    localparam logic [7:0]  A_SLOW_INC  = 8'h20;
    localparam logic [7:0]  A_SLP_CFG   = 8'h24;
    localparam int          DSM_BIT     = 7;
    localparam int          DSM_WORDS   = 32;
    // control bits
    localparam int          C_SLEEP     = 0;
    localparam int          C_WD_EN     = 1;
    localparam int          C_USB_EN    = 2;
    localparam int          C_SLOW_EN   = 3;
    localparam int          C_PIN_EN    = 4;
    localparam int          C_PIN_POL   = 5;
    localparam int          C_RTC_EN    = 6;
    localparam int          CTRL_W      = 7;
    localparam logic [6:0]  CTRL_RST    = 7'h00;
    // status bits
    localparam int          S_WDRST     = 4;
    localparam int          S_PEND      = 8;
    // reset values
    localparam logic [15:0] WD_TMO_RST  = 16'h03e8;
    localparam logic [31:0] SLOW_INC_RST = 32'h00000320;
    localparam int          CFG_W       = 2 * NSUP + 2;
    localparam logic [9:0]  SLP_CFG_RST = 10'h00f;
    // timing
    localparam int          CLK_NS      = 40;
    localparam int          MS_NS       = 1000000;
    localparam int          MS_CYC      = MS_NS / CLK_NS;
    localparam logic [4:0]  WD_RST_CYC  = 5'h10;
    // synchroniser order {slow, pin, ext_rst_n, pgood}
    localparam int          SYNC_W      = NSUP + 3;
    localparam logic [6:0]  SYNC_RST    = 7'h10;

    typedef enum logic [2:0] {
        ST_AWAKE  = 3'b000,
        ST_S_CLK  = 3'b001,
        ST_S_RST  = 3'b010,
        ST_S_SUP  = 3'b011,
        ST_ASLEEP = 3'b100,
        ST_W_SUP  = 3'b101,
        ST_W_RST  = 3'b110,
        ST_W_CLK  = 3'b111
    } sswc_state_t;

    typedef struct packed {
        logic            core_rst;
        logic            clk_mask;
        logic [NSUP-1:0] pulse_frequency_supply_mode;
        logic [NSUP-1:0] en;
    } sswc_pwr_t;
endpackage

/* verilog/sswc_top.sv */
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Contract
// - hold chip reset after power-up until every supply is good
// - external active-low reset is optional and may float high
// - supply loss outside the wake wait for supplies forces reset until recovery, then cold restart
// - watchdog is 16-bit, millisecond ticks, timeout 1 ms to 65 s
// - watchdog and real-time counter never touch each other
// - software must re-set watchdog; expiry resets the chip
// - software can read whether last reset came from watchdog
// - watchdog counts only in the running state
// - deep sleep and running states joined by transition states
// - control write or usb standby entry starts the sleep sequence
// - usb standby exit, pin or timer event starts waking
// - wake stimuli act only asleep; ones arriving during the sleep steps are held
// - wake on pin edge, counter compare match, or usb wakeup
// - while awake the counter adds one per main clock
// - asleep the counter may add a programmed step per slow tick
// - deep sleep powers down supplies; running keeps all powered
// - 128 bytes of memory keep their contents across sleep
// - supply loss during a sleep transition or the wake reset and clock steps resets the chip
module sswc_top #(
    parameter int P_MS_CYC = sswc_pkg::MS_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [sswc_pkg::NSUP-1:0] pgood,
    input  wire logic             ext_rst_n,
    input  wire logic             wake_pin,
    input  wire logic             slow_osc,
    input  wire logic             usb_standby_enter,
    input  wire logic             usb_standby_exit,
    output logic                  sys_rst_n,
    output sswc_pkg::sswc_pwr_t   pwr,
    output logic                  asleep
);
    localparam int PW = $clog2(P_MS_CYC + 1);

    sswc_pkg::sswc_state_t st_q;
    sswc_pkg::sswc_pwr_t   pwr_q;
    logic [sswc_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, cln_q;
    logic [sswc_pkg::CTRL_W-1:0] ctrl_q;
    logic [sswc_pkg::CFG_W-1:0]  cfg_q;
    logic [15:0]      wd_tmo_q, wd_cnt_q;
    logic [PW-1:0]    ms_q;
    logic [4:0]       rcnt_q;
    logic             wd_flag_q, sys_rst_n_q;
    logic [63:0]      rtc_q, cmp_q;
    logic [31:0]      inc_q, rd_d, prdata_q;
    logic             err_q, pin_p_q, slow_p_q;
    logic [2:0]       pend_q, ev;
    logic [31:0]      dsm_q [sswc_pkg::DSM_WORDS];
    logic             wr, rd, hit_dsm, map_ok, pg_ok, pg_all;
    logic             wd_fire, wd_run, ms_tick, sleep_req, sleeping;
    logic             pin_c, slow_c, slow_tick, ext_ok, wake_any;

    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~penable;
    assign hit_dsm = paddr[sswc_pkg::DSM_BIT];
    assign pready  = psel & penable;
    assign prdata  = prdata_q;
    assign pslverr = pready & err_q;

    // input synchroniser: a level moves only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= sswc_pkg::SYNC_RST;
            s2_q  <= sswc_pkg::SYNC_RST;
            s3_q  <= sswc_pkg::SYNC_RST;
            cln_q <= sswc_pkg::SYNC_RST;
        end else begin
            s1_q  <= {slow_osc, wake_pin, ext_rst_n, pgood};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            cln_q <= (s2_q & s3_q) | (cln_q & (s2_q | s3_q));
        end
    end

    assign ext_ok = cln_q[sswc_pkg::NSUP];
    assign pin_c  = cln_q[sswc_pkg::NSUP+1];
    assign slow_c = cln_q[sswc_pkg::NSUP+2];
    // a supply switched off for sleep is not watched
    assign pg_ok  = &(cln_q[sswc_pkg::NSUP-1:0] | ~pwr_q.en);
    assign pg_all = &cln_q[sswc_pkg::NSUP-1:0];

    // chip reset: power-on, brown-out, external and watchdog sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_n_q <= 1'b0;
            rcnt_q      <= 5'h00;
        end else begin
            if (wd_fire) begin
                rcnt_q <= sswc_pkg::WD_RST_CYC;
            end else if (rcnt_q != 5'h00) begin
                rcnt_q <= rcnt_q - 5'h01;
            end
            // the wait for supplies while waking is not a loss
            sys_rst_n_q <= (pg_ok | st_q == sswc_pkg::ST_W_SUP)
                & ext_ok & ~wd_fire & rcnt_q == 5'h00;
        end
    end
    assign sys_rst_n = sys_rst_n_q;

    // watchdog on its own millisecond prescaler, apart from the rtc
    assign wd_run  = ctrl_q[sswc_pkg::C_WD_EN] & sys_rst_n_q
        & st_q == sswc_pkg::ST_AWAKE;
    assign ms_tick = ms_q == PW'(P_MS_CYC - 1);
    assign wd_fire = wd_run & ms_tick & wd_cnt_q == 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_q     <= '0;
            wd_cnt_q <= sswc_pkg::WD_TMO_RST;
        end else if (wr & ~hit_dsm & paddr == sswc_pkg::A_WD_KICK
                     & st_q == sswc_pkg::ST_AWAKE) begin
            ms_q     <= '0;
            wd_cnt_q <= wd_tmo_q;
        end else if (wd_run) begin
            ms_q <= ms_tick ? '0 : ms_q + PW'(1);
            if (ms_tick) begin
                wd_cnt_q <= wd_fire ? wd_tmo_q : wd_cnt_q - 16'h0001;
            end
        end
    end

    // watchdog cause flag: set wins over the software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_flag_q <= 1'b0;
        end else if (wd_fire) begin
            wd_flag_q <= 1'b1;
        end else if (~pg_ok & st_q != sswc_pkg::ST_W_SUP | ~ext_ok) begin
            wd_flag_q <= 1'b0;
        end else if (wr & ~hit_dsm & paddr == sswc_pkg::A_STAT
                     & pwdata[sswc_pkg::S_WDRST]) begin
            wd_flag_q <= 1'b0;
        end
    end

    // real-time counter
    assign slow_tick = slow_c & ~slow_p_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_q    <= 64'h0;
            slow_p_q <= 1'b0;
        end else begin
            slow_p_q <= slow_c;
            if (wr & ~hit_dsm & paddr == sswc_pkg::A_RTC_LO) begin
                rtc_q[31:0] <= pwdata;
            end else if (wr & ~hit_dsm & paddr == sswc_pkg::A_RTC_HI) begin
                rtc_q[63:32] <= pwdata;
            end else if (st_q == sswc_pkg::ST_ASLEEP
                         & ctrl_q[sswc_pkg::C_SLOW_EN]) begin
                if (slow_tick) begin
                    rtc_q <= rtc_q + {32'h0, inc_q};
                end
            end else begin
                rtc_q <= rtc_q + 64'h1;
            end
        end
    end

    // wake sources, held from the first sleep step until acted on
    // only the sleep steps and deep sleep hold events; wake steps drop them
    assign sleeping = st_q != sswc_pkg::ST_AWAKE & st_q[2] == 1'b0
        | st_q == sswc_pkg::ST_ASLEEP;
    assign ev[0] = ctrl_q[sswc_pkg::C_PIN_EN] & pin_c != pin_p_q
        & pin_c == ctrl_q[sswc_pkg::C_PIN_POL];
    assign ev[1] = ctrl_q[sswc_pkg::C_RTC_EN] & rtc_q >= cmp_q;
    assign ev[2] = ctrl_q[sswc_pkg::C_USB_EN] & usb_standby_exit;
    assign wake_any = |pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q  <= 3'h0;
            pin_p_q <= 1'b0;
        end else begin
            pin_p_q <= pin_c;
            if (st_q == sswc_pkg::ST_ASLEEP & wake_any) begin
                pend_q <= 3'h0;
            end else if (sleeping) begin
                pend_q <= pend_q | ev;
            end else begin
                pend_q <= 3'h0;
            end
        end
    end

    // power mode sequencer; one supply, clock or reset change per step
    assign sleep_req = wr & ~hit_dsm & paddr == sswc_pkg::A_CTRL
        & pwdata[sswc_pkg::C_SLEEP]
        | ctrl_q[sswc_pkg::C_USB_EN] & usb_standby_enter;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= sswc_pkg::ST_AWAKE;
            pwr_q <= '{default: '0, en: '1};
        end else if (~sys_rst_n_q) begin
            // cold restart brings back the running configuration
            st_q  <= sswc_pkg::ST_AWAKE;
            pwr_q <= '{default: '0, en: '1};
        end else begin
            case (st_q)
                sswc_pkg::ST_AWAKE: begin
                    if (sleep_req) begin
                        st_q <= sswc_pkg::ST_S_CLK;
                    end
                end
                sswc_pkg::ST_S_CLK: begin
                    pwr_q.clk_mask <= cfg_q[sswc_pkg::CFG_W-2];
                    st_q           <= sswc_pkg::ST_S_RST;
                end
                sswc_pkg::ST_S_RST: begin
                    pwr_q.core_rst <= cfg_q[sswc_pkg::CFG_W-1];
                    st_q           <= sswc_pkg::ST_S_SUP;
                end
                sswc_pkg::ST_S_SUP: begin
                    pwr_q.en <= cfg_q[sswc_pkg::NSUP-1:0];
                    pwr_q.pulse_frequency_supply_mode <=
                        cfg_q[2*sswc_pkg::NSUP-1:sswc_pkg::NSUP];
                    st_q <= sswc_pkg::ST_ASLEEP;
                end
                sswc_pkg::ST_ASLEEP: begin
                    if (wake_any) begin
                        pwr_q.en <= '1;
                        pwr_q.pulse_frequency_supply_mode <= '0;
                        st_q <= sswc_pkg::ST_W_SUP;
                    end
                end
                sswc_pkg::ST_W_SUP: begin
                    if (pg_all) begin
                        st_q <= sswc_pkg::ST_W_RST;
                    end
                end
                sswc_pkg::ST_W_RST: begin
                    pwr_q.core_rst <= 1'b0;
                    st_q           <= sswc_pkg::ST_W_CLK;
                end
                sswc_pkg::ST_W_CLK: begin
                    pwr_q.clk_mask <= 1'b0;
                    st_q           <= sswc_pkg::ST_AWAKE;
                end
                default: begin
                    st_q <= sswc_pkg::ST_AWAKE;
                end
            endcase
        end
    end
    assign pwr    = pwr_q;
    assign asleep = st_q == sswc_pkg::ST_ASLEEP;

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= sswc_pkg::CTRL_RST;
            cfg_q    <= sswc_pkg::SLP_CFG_RST;
            wd_tmo_q <= sswc_pkg::WD_TMO_RST;
            cmp_q    <= 64'h0;
            inc_q    <= sswc_pkg::SLOW_INC_RST;
        end else if (wr & ~hit_dsm) begin
            case (paddr)
                sswc_pkg::A_CTRL: begin
                    // the sleep bit is a strobe and is never stored
                    ctrl_q <= {pwdata[sswc_pkg::CTRL_W-1:1], 1'b0};
                end
                sswc_pkg::A_SLP_CFG:  cfg_q <= pwdata[sswc_pkg::CFG_W-1:0];
                sswc_pkg::A_WD_TMO: begin
                    // zero would wrap and expire only after 65536 ms, so it counts as 1 ms
                    wd_tmo_q <= pwdata[15:0] == 16'h0 ? 16'h0001
                        : pwdata[15:0];
                end
                sswc_pkg::A_CMP_LO:   cmp_q[31:0]  <= pwdata;
                sswc_pkg::A_CMP_HI:   cmp_q[63:32] <= pwdata;
                sswc_pkg::A_SLOW_INC: inc_q        <= pwdata;
                default: begin
                end
            endcase
        end
    end

    // deep-sleep memory: no reset, content stays while powered
    always_ff @(posedge pclk) begin
        if (wr & hit_dsm) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    dsm_q[paddr[6:2]][8*b +: 8] <= pwdata[8*b +: 8];
                end
            end
        end
    end

    always_comb begin
        rd_d   = 32'h0;
        map_ok = 1'b1;
        if (hit_dsm) begin
            rd_d = dsm_q[paddr[6:2]];
        end else begin
            case (paddr)
                sswc_pkg::A_CTRL:     rd_d = 32'(ctrl_q);
                sswc_pkg::A_STAT: begin
                    rd_d[2:0] = st_q;
                    rd_d[sswc_pkg::S_WDRST] = wd_flag_q;
                    rd_d[sswc_pkg::S_PEND +: 3] = pend_q;
                end
                sswc_pkg::A_WD_TMO:   rd_d = {16'h0, wd_tmo_q};
                sswc_pkg::A_WD_KICK:  rd_d = {16'h0, wd_cnt_q};
                sswc_pkg::A_RTC_LO:   rd_d = rtc_q[31:0];
                sswc_pkg::A_RTC_HI:   rd_d = rtc_q[63:32];
                sswc_pkg::A_CMP_LO:   rd_d = cmp_q[31:0];
                sswc_pkg::A_CMP_HI:   rd_d = cmp_q[63:32];
                sswc_pkg::A_SLOW_INC: rd_d = inc_q;
                sswc_pkg::A_SLP_CFG:  rd_d = 32'(cfg_q);
                default:              map_ok = 1'b0;
            endcase
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            err_q    <= 1'b0;
        end else if (rd) begin
            prdata_q <= pwrite ? 32'h0 : rd_d;
            err_q    <= ~map_ok;
        end
    end

    a_wd_stop: assert property (@(posedge pclk) disable iff (!presetn)
        st_q != sswc_pkg::ST_AWAKE |=> $stable(wd_cnt_q))
        else $error("watchdog moved outside running state");
    a_wd_fire_rst: assert property (@(posedge pclk) disable iff (!presetn)
        wd_fire |=> !sys_rst_n ##1 !sys_rst_n[*8])
        else $error("watchdog expiry did not hold reset");
    a_wd_flag: assert property (@(posedge pclk) disable iff (!presetn)
        wd_fire |=> wd_flag_q)
        else $error("watchdog cause flag not set");
    a_pg_rst: assert property (@(posedge pclk) disable iff (!presetn)
        !pg_ok && st_q != sswc_pkg::ST_W_SUP |=> !sys_rst_n)
        else $error("supply loss did not reset chip");
    a_sleep_go: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == sswc_pkg::ST_AWAKE && sleep_req && sys_rst_n
        |=> st_q == sswc_pkg::ST_S_CLK ##1 st_q == sswc_pkg::ST_S_RST)
        else $error("sleep request not followed");
    a_seq_step: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == sswc_pkg::ST_S_RST && sys_rst_n
        |=> st_q == sswc_pkg::ST_S_SUP && pwr.core_rst == cfg_q[9])
        else $error("sleep step skipped");
    a_rtc_awake: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == sswc_pkg::ST_AWAKE && !wr |=> rtc_q == $past(rtc_q) + 64'h1)
        else $error("counter did not tick while awake");
    a_wake_go: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == sswc_pkg::ST_ASLEEP && wake_any && sys_rst_n
        |=> st_q == sswc_pkg::ST_W_SUP && pend_q == 3'h0)
        else $error("held wake not acted on");
endmodule

/* sim/sswc_supply_model.sv */
`timescale 1ns/1ps
// power-good rises two cycles after each enable and falls one cycle after it, so a supply that is
// switched back on is never good at once
module sswc_supply_model (
    input  wire logic                      pclk,
    input  wire logic [sswc_pkg::NSUP-1:0] en,
    input  wire logic [sswc_pkg::NSUP-1:0] fail,
    output logic      [sswc_pkg::NSUP-1:0] pgood,
    output logic                           slow_osc
);
    logic [sswc_pkg::NSUP-1:0] ramp_q;

    initial begin
        ramp_q   = '0;
        pgood    = '0;
        slow_osc = 1'b0;
    end
    // free-running slow oscillator, its edges always falling on pclk falling edges
    always #16000 slow_osc = ~slow_osc;

    always @(posedge pclk) begin
        ramp_q <= en & ~fail;
        pgood  <= ramp_q & en & ~fail;
    end
endmodule

/* sim/tb_supervisor_sleep_wake_control.sv */
`timescale 1ns/1ps
module tb_supervisor_sleep_wake_control;
    logic                      pclk;
    logic                      presetn;
    logic [7:0]                paddr;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [sswc_pkg::NSUP-1:0] pgood;
    logic [sswc_pkg::NSUP-1:0] fail;
    logic                      wake_pin;
    logic                      slow_osc;
    logic                      usb_enter;
    logic                      usb_exit;
    logic                      sys_rst_n;
    sswc_pkg::sswc_pwr_t       pwr;
    logic                      asleep;
    logic [31:0]               rd;
    logic [31:0]               a;
    logic                      err;
    int                        n;
    int                        mismatches;
    int                        checks_done;

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    sswc_top #(.P_MS_CYC(10)) u_sswc_top (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pgood(pgood),
        .ext_rst_n(1'b1),
        .wake_pin(wake_pin), .slow_osc(slow_osc),
        .usb_standby_enter(usb_enter), .usb_standby_exit(usb_exit),
        .sys_rst_n(sys_rst_n), .pwr(pwr), .asleep(asleep)
    );
    sswc_supply_model u_sswc_supply_model (
        .pclk(pclk), .en(pwr.en), .fail(fail), .pgood(pgood),
        .slow_osc(slow_osc)
    );

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        if (k >= 20) mismatches++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] ad,
                          input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(nm, rd, exp);
    endtask
    // sel picks sys_rst_n (1) or asleep (0); n returns the cycles taken
    task automatic wait_sig(input bit sel, input logic lvl, input int lim);
        n = 0;
        while ((sel ? sys_rst_n : asleep) !== lvl && n <= lim) begin
            @(posedge pclk);
            n++;
        end
        chk(sel ? "sys_rst_n" : "asleep", n <= lim, 32'h1);
    endtask
    task automatic go_sleep(input logic [31:0] c);
        wr(sswc_pkg::A_CTRL, c | 32'h1);
        wait_sig(1'b0, 1'b1, 10);
        chk("sleep_steps", n, 4);
        chk("pwr_asleep", {22'h0, pwr}, 32'h3f2);
        rd_chk("state", sswc_pkg::A_STAT, 32'h4);
    endtask

    initial begin
        #(20000 * 40);
        mismatches++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, wake_pin} = '0;
        {usb_enter, usb_exit, paddr, pwdata} = '0;
        {mismatches, checks_done} = '0;
        fail = 4'h1;
        repeat (20) @(posedge pclk);
        chk("rst_hold", sys_rst_n, 32'h0);
        chk("pwr_reset", {22'h0, pwr}, 32'h00f);
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("por_wait", sys_rst_n, 32'h0);
        fail <= 4'h0;
        wait_sig(1'b1, 1'b1, 20);
        rd_chk("wd_tmo", sswc_pkg::A_WD_TMO, 32'h3e8);
        rd_chk("slow_inc", sswc_pkg::A_SLOW_INC, 32'h320);
        rd_chk("slp_cfg", sswc_pkg::A_SLP_CFG, 32'h00f);
        rd_chk("stat", sswc_pkg::A_STAT, 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        chk("pslverr", err, 32'h1);
        chk("unmapped", rd, 32'h0);
        wr(sswc_pkg::A_WD_TMO, 32'h3);
        wr(sswc_pkg::A_CTRL, 32'h2);
        apb(1'b0, sswc_pkg::A_RTC_LO, 32'h0);
        a = rd;
        wr(sswc_pkg::A_WD_KICK, 32'h0);
        rd_chk("rtc_step", sswc_pkg::A_RTC_LO, a + 32'h6);
        repeat (6) begin
            repeat (5) @(posedge pclk);
            wr(sswc_pkg::A_WD_KICK, 32'h0);
        end
        chk("wd_kept", sys_rst_n, 32'h1);
        wait_sig(1'b1, 1'b0, 40);
        chk("wd_reload", n >= 18, 32'h1);
        wait_sig(1'b1, 1'b1, 40);
        chk("wd_width", n, 17);
        wr(sswc_pkg::A_CTRL, 32'h0);
        rd_chk("wd_flag", sswc_pkg::A_STAT, 32'h10);
        wr(sswc_pkg::A_STAT, 32'h10);
        rd_chk("wd_clear", sswc_pkg::A_STAT, 32'h0);
        wr(sswc_pkg::A_WD_TMO, 32'd1000);
        wr(sswc_pkg::A_WD_KICK, 32'h0);
        // lowest-power sleep setting: only the second buck stays on
        wr(sswc_pkg::A_SLP_CFG, 32'h3f2);
        wr(8'h80, 32'h5a5ac3c3);
        wr(sswc_pkg::A_CTRL, 32'h36);
        usb_exit <= 1'b1;
        @(posedge pclk);
        usb_exit <= 1'b0;
        go_sleep(32'h36);
        apb(1'b0, sswc_pkg::A_WD_KICK, 32'h0);
        a = rd;
        repeat (40) @(posedge pclk);
        rd_chk("wd_frozen", sswc_pkg::A_WD_KICK, a);
        chk("held_asleep", asleep, 32'h1);
        wake_pin <= 1'b1;
        wait_sig(1'b0, 1'b0, 40);
        repeat (20) @(posedge pclk);
        chk("pwr_awake", {22'h0, pwr}, 32'h00f);
        rd_chk("dsm", 8'h80, 32'h5a5ac3c3);
        usb_enter <= 1'b1;
        @(posedge pclk);
        usb_enter <= 1'b0;
        usb_exit  <= 1'b1;
        @(posedge pclk);
        usb_exit  <= 1'b0;
        wait_sig(1'b0, 1'b1, 10);
        wait_sig(1'b0, 1'b0, 40);
        repeat (20) @(posedge pclk);
        apb(1'b0, sswc_pkg::A_RTC_LO, 32'h0);
        a = rd + 32'd3000;
        wr(sswc_pkg::A_CMP_HI, 32'h0);
        wr(sswc_pkg::A_CMP_LO, a);
        go_sleep(32'h4a);
        @(posedge slow_osc);
        repeat (10) @(posedge pclk);
        apb(1'b0, sswc_pkg::A_RTC_LO, 32'h0);
        @(posedge slow_osc);
        repeat (10) @(posedge pclk);
        rd_chk("slow_step", sswc_pkg::A_RTC_LO, rd + 32'd800);
        wait_sig(1'b0, 1'b0, 4000);
        apb(1'b0, sswc_pkg::A_RTC_LO, 32'h0);
        chk("rtc_match", rd >= a, 32'h1);
        repeat (20) @(posedge pclk);
        wr(sswc_pkg::A_CTRL, 32'h1);
        fail <= 4'h2;
        wait_sig(1'b1, 1'b0, 12);
        fail <= 4'h0;
        wait_sig(1'b1, 1'b1, 40);
        chk("cold_pwr", {22'h0, pwr}, 32'h00f);
        chk("cold_state", asleep, 32'h0);
        conclude();
    end
endmodule
